//--- tiec_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module tiec_chk
	import tiec_pkg::*;
(
	input wire logic        sys_clk_i,
	input wire logic        sys_rst_i,
	input wire logic [7:0]  io_addr_i,
	input wire logic        io_rd_i,
	input wire logic [7:0]  io_rdata_o,
	input wire logic        undef_opcode_i,
	input wire logic        sample_point_i,
	input wire logic        enable_interrupts_instruction_i,
	input wire logic        disable_interrupts_instruction_i,
	input wire logic        return_from_non_maskable_i,
	input wire logic        load_a_special_i,
	input wire logic        int_accept_i,
	input wire logic        trap_req_o,
	input wire logic [2:0]  irq_kind_o,
	input wire logic [15:0] restart_addr_o,
	input wire logic        push_pc_o,
	input wire logic        trap_insert_state_o,
	input wire logic        inhibit_insert_o,
	input wire logic        parity_flag_o,
	input wire logic        parity_flag_we_o,
	input wire logic        global_enable_flag_o,
	input wire logic        shadow_enable_flag_o
);
	// No accept, enable or disable in this cycle, so a checked flag change is not overtaken
	wire logic ot = !(int_accept_i || enable_interrupts_instruction_i
		|| disable_interrupts_instruction_i);
	wire logic qt = ot && !return_from_non_maskable_i;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_di;
		disable_interrupts_instruction_i && !int_accept_i ##1 qt;
	endsequence
	sequence s_ei;
		enable_interrupts_instruction_i && !disable_interrupts_instruction_i
			&& !int_accept_i ##1 qt;
	endsequence
	////////////////////////////////////////////////////////////////////////
	a_trap_entry: assert property (undef_opcode_i |=> trap_req_o && push_pc_o
		&& restart_addr_o == 16'h0000) else $error("trap entry wrong");
	a_trap_insert: assert property (undef_opcode_i |=> trap_insert_state_o
		##1 inhibit_insert_o) else $error("no insert guard after trap");
	a_di_clears: assert property (s_di |=> !global_enable_flag_o
		&& !shadow_enable_flag_o) else $error("disable left a flag set");
	a_ei_sets: assert property (s_ei |=> global_enable_flag_o
		&& shadow_enable_flag_o) else $error("enable left a flag clear");
	a_nmi_save: assert property (int_accept_i && irq_kind_o == TIEC_ACC_NMI ##1 qt
		|=> !global_enable_flag_o && restart_addr_o == 16'h0066
		&& shadow_enable_flag_o == $past(global_enable_flag_o)) else $error("nmi save");
	a_nmi_push: assert property (int_accept_i && irq_kind_o == TIEC_ACC_NMI
		|=> push_pc_o) else $error("nmi accept pushed no pc");
	a_mask_accept: assert property (int_accept_i && irq_kind_o >= 3'h2 ##1 qt
		|=> !global_enable_flag_o && !shadow_enable_flag_o) else $error("accept flags");
	a_return_from_non_maskable_restore: assert property (return_from_non_maskable_i && ot ##1 qt |=>
		global_enable_flag_o == $past(shadow_enable_flag_o) && $stable(shadow_enable_flag_o))
		else $error("return from nmi restore");
	a_mask_refused: assert property (sample_point_i && !global_enable_flag_o |=>
		global_enable_flag_o || irq_kind_o <= 3'h1) else $error("maskable not refused");
	a_unused_zero: assert property (io_rd_i && io_addr_i == 8'h34
		|=> io_rdata_o[5:3] == 3'h0) else $error("unused bits nonzero");
	a_parity_copy: assert property (load_a_special_i && qt |=> parity_flag_we_o
		&& parity_flag_o == global_enable_flag_o) else $error("parity copy wrong");
endmodule
bind tiec_top tiec_chk i_chk (.*);
`default_nettype wire

//--- tiec_defines.svh
`ifndef TIEC_DEFINES_SVH
`define TIEC_DEFINES_SVH
// Register offset on the internal I/O bus
`define TIEC_CTRL_ADDR      8'h34
// Field positions of the trap/control register
`define TIEC_TRAP_BIT       7
`define TIEC_POS_BIT        6
`define TIEC_EN2_BIT        2
`define TIEC_EN1_BIT        1
`define TIEC_EN0_BIT        0
// Reset values
`define TIEC_EN_RST         3'h1
// Restart addresses
`define TIEC_TRAP_VEC       16'h0000
`define TIEC_NMI_VEC        16'h0066
`define TIEC_MODE1_VEC      16'h0038
`endif

//--- tiec_pkg.sv
package tiec_pkg;
	// Level 0 response modes
	typedef enum logic [1:0] {
		TIEC_MODE0 = 2'h0,
		TIEC_MODE1 = 2'h1,
		TIEC_MODE2 = 2'h2
	} tiec_mode_t;
	// Interrupt taken, binary-coded kind
	typedef enum logic [2:0] {
		TIEC_ACC_NONE = 3'h0,
		TIEC_ACC_NMI  = 3'h1,
		TIEC_ACC_MASKABLE_LEVEL0_INPUT = 3'h2,
		TIEC_ACC_MASKABLE_LEVEL1_INPUT = 3'h3,
		TIEC_ACC_MASKABLE_LEVEL2_INPUT = 3'h4
	} tiec_acc_t;
endpackage

//--- tiec_requester.sv
`timescale 1ns/1ps
`default_nettype none
module tiec_requester (
	input  wire logic [3:0] req_i,
	output logic            nmi_n_o,
	output logic            lvl0_n_o,
	output logic            lvl1_n_o,
	output logic            lvl2_n_o
);
	// Pins low while requested, pulled high otherwise
	assign {lvl2_n_o, lvl1_n_o, lvl0_n_o, nmi_n_o} = ~req_i;
endmodule
`default_nettype wire

//--- tiec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import tiec_pkg::*;
	logic        sys_clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdat = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        third = 1'b0;
	logic [8:0]  ev = 9'h000;
	logic        ack0 = 1'b0;
	logic [1:0]  msel = 2'h0;
	logic        ireq = 1'b0;
	logic        vld;
	logic [1:0]  lmode;
	logic [3:0]  req = 4'h0;
	wire logic [3:0] pin;
	logic [7:0]  rdat;
	logic [2:0]  kind;
	logic [15:0] ra;
	logic        gie;
	logic        sie;
	logic        par;
	int          err_total = 0;
	int          total_checks = 0;
	// Clock at 200 MHz
	always #2.5 sys_clk_i = ~sys_clk_i;
	tiec_requester i_req (.req_i(req), .nmi_n_o(pin[0]), .lvl0_n_o(pin[1]),
		.lvl1_n_o(pin[2]), .lvl2_n_o(pin[3]));
	tiec_top i_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .io_addr_i(addr),
		.io_wdata_i(wdat), .io_wr_i(wr), .io_rd_i(rd), .io_rdata_o(rdat),
		.nmi_n_i(pin[0]), .maskable_level0_input_n_i(pin[1]),
		.maskable_level1_input_n_i(pin[2]), .maskable_level2_input_n_i(pin[3]),
		.undef_opcode_i(ev[0]), .undef_third_byte_i(third), .ack_mode0_fetch_i(ack0),
		.sample_point_i(ev[7]), .enable_interrupts_instruction_i(ev[1]),
		.disable_interrupts_instruction_i(ev[2]), .return_from_non_maskable_i(ev[3]),
		.return_from_interrupt_i(ev[4]), .load_a_special_i(ev[5]),
		.int_accept_i(ev[6]), .mode_set_i(msel), .mode_set_en_i(ev[8]),
		.internal_req_i(ireq), .trap_req_o(), .irq_valid_o(vld), .irq_kind_o(kind),
		.level0_mode_o(lmode), .restart_addr_o(ra), .push_pc_o(), .trap_insert_state_o(),
		.inhibit_insert_o(), .parity_flag_o(par), .parity_flag_we_o(),
		.global_enable_flag_o(gie), .shadow_enable_flag_o(sie));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic ev_p(input int n);
		ev[n] = 1'b1;
		tick(1);
		ev[n] = 1'b0;
		tick(1);
	endtask
	task automatic wr_r(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdat = d;
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
		tick(1);
	endtask
	task automatic rd_r(input logic [7:0] a, input logic [7:0] exp);
		addr = a;
		rd = 1'b1;
		tick(1);
		rd = 1'b0;
		chk(rdat, exp);
		tick(1);
	endtask
	// Let the pins settle through the synchroniser, then sample
	task automatic smp(input logic [2:0] exp);
		tick(4);
		ev_p(7);
		chk(kind, exp);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Watchdog
	initial begin
		#20000;
		err_total++;
		end_of_test;
	end
	// Main sequence
	initial begin
		tick(2);
		sys_rst_i = 1'b0;
		tick(3);
		chk({gie, sie}, 2'b00);
		rd_r(8'h34, 8'h01);
		wr_r(8'h34, 8'hff);
		rd_r(8'h34, 8'h07);
		wr_r(8'h35, 8'h00);
		rd_r(8'h35, 8'h00);
		rd_r(8'h34, 8'h07);
		$display("test registers done");
		third = 1'b1;
		ev_p(0);
		third = 1'b0;
		rd_r(8'h34, 8'hc7);
		chk(ra, 16'h0000);
		wr_r(8'h34, 8'h80);
		rd_r(8'h34, 8'hc0);
		wr_r(8'h34, 8'h01);
		rd_r(8'h34, 8'h41);
		wr_r(8'h34, 8'h81);
		rd_r(8'h34, 8'h41);
		ev_p(0);
		rd_r(8'h34, 8'h81);
		$display("test trap done");
		// Each level: enable bit off, global off, then both on
		for (int i = 0; i < 3; i++) begin
			req = 4'h2 << i;
			wr_r(8'h34, 8'h00);
			ev_p(1);
			smp(3'h0);
			wr_r(8'h34, 8'h01 << i);
			ev_p(2);
			smp(3'h0);
			ev_p(1);
			smp(3'(i + 2));
			ev_p(4);
			chk({gie, sie}, 2'b11);
			ev_p(6);
			chk({gie, sie}, 2'b00);
			req = 4'h0;
		end
		$display("test maskable done");
		ev_p(1);
		req = 4'h1;
		smp(3'h1);
		ev_p(6);
		chk({gie, sie}, 2'b01);
		chk(ra, 16'h0066);
		req = 4'h0;
		ev_p(5);
		chk(par, 1'b0);
		ev_p(3);
		chk({gie, sie}, 2'b11);
		ev_p(5);
		chk(par, 1'b1);
		ev_p(2);
		chk({gie, sie}, 2'b00);
		$display("test nmi done");
		// Internal request follows the global flag
		ireq = 1'b1;
		tick(1);
		chk(vld, 1'b0);
		ev_p(1);
		chk(vld, 1'b1);
		ireq = 1'b0;
		tick(1);
		chk(vld, 1'b0);
		// Level 0 in mode 1 restarts at its fixed address
		msel = 2'h1;
		ev_p(8);
		chk(lmode, 2'h1);
		wr_r(8'h34, 8'h01);
		req = 4'h2;
		smp(3'h2);
		ev_p(6);
		chk(ra, 16'h0038);
		chk({gie, sie}, 2'b00);
		req = 4'h0;
		// Undefined opcode during a mode 0 acknowledge, flags left alone
		ev_p(1);
		ack0 = 1'b1;
		ev_p(0);
		ack0 = 1'b0;
		rd_r(8'h34, 8'h81);
		chk(ra, 16'h0000);
		chk({gie, sie}, 2'b11);
		$display("test modes done");
		end_of_test;
	end
endmodule
`default_nettype wire

//--- tiec_top.sv
`include "tiec_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tiec_top
	import tiec_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        sys_rst_i,
	// Internal I/O register bus
	input  wire logic [7:0]  io_addr_i,
	input  wire logic [7:0]  io_wdata_i,
	input  wire logic        io_wr_i,
	input  wire logic        io_rd_i,
	output logic      [7:0]  io_rdata_o,
	// External request pins, active low
	input  wire logic        nmi_n_i,
	input  wire logic        maskable_level0_input_n_i,
	input  wire logic        maskable_level1_input_n_i,
	input  wire logic        maskable_level2_input_n_i,
	// Sequencer events, one-cycle pulses
	input  wire logic        undef_opcode_i,
	input  wire logic        undef_third_byte_i,
	input  wire logic        ack_mode0_fetch_i,
	input  wire logic        sample_point_i,
	input  wire logic        enable_interrupts_instruction_i,
	input  wire logic        disable_interrupts_instruction_i,
	input  wire logic        return_from_non_maskable_i,
	input  wire logic        return_from_interrupt_i,
	input  wire logic        load_a_special_i,
	input  wire logic        int_accept_i,
	input  wire logic [1:0]  mode_set_i,
	input  wire logic        mode_set_en_i,
	input  wire logic        internal_req_i,
	// Requests to the sequencer
	output logic             trap_req_o,
	output logic             irq_valid_o,
	output logic      [2:0]  irq_kind_o,
	output logic      [1:0]  level0_mode_o,
	output logic      [15:0] restart_addr_o,
	output logic             push_pc_o,
	output logic             trap_insert_state_o,
	output logic             inhibit_insert_o,
	output logic             parity_flag_o,
	output logic             parity_flag_we_o,
	output logic             global_enable_flag_o,
	output logic             shadow_enable_flag_o
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: every pin passes two flops before any logic reads it.
	// They reset to the idle high level, so release of reset shows no false
	// falling edge on the non-maskable pin and no phantom maskable request
	// in the first cycles after reset.
	logic [3:0] pin_meta_q;
	logic [3:0] pin_sync_q;
	logic       nmi_prev_q;
	logic       nmi_pend_q;

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			pin_meta_q <= 4'hf;
			pin_sync_q <= 4'hf;
		end else begin
			pin_meta_q <= {maskable_level2_input_n_i, maskable_level1_input_n_i,
				maskable_level0_input_n_i, nmi_n_i};
			pin_sync_q <= pin_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control register fields
	logic       trap_q;
	logic       pos_q;
	logic [2:0] in_en_q;

	// Enable flags, level 0 mode and the pending selection
	logic       gie_q;
	logic       shadow_q;
	tiec_mode_t mode_q;
	tiec_acc_t  acc_q;

	// Decoded strobes of this cycle
	logic       wr_ctrl;
	logic       trap_hit;
	logic       nmi_fall;
	logic       accept_nmi;
	logic       accept_mask;

	// Control register write, trap detection and accept decode; an accept
	// acts on the kind that was selected at the last sample point
	assign wr_ctrl  = io_wr_i && (io_addr_i == `TIEC_CTRL_ADDR);
	assign trap_hit = undef_opcode_i || (ack_mode0_fetch_i && undef_opcode_i);
	assign nmi_fall = nmi_prev_q && !pin_sync_q[0];
	assign accept_nmi  = int_accept_i && (acc_q == TIEC_ACC_NMI);
	assign accept_mask = int_accept_i && (acc_q != TIEC_ACC_NMI) && (acc_q != TIEC_ACC_NONE);

	// Trap flag: hardware set wins over a software clear in the same cycle,
	// so an undefined opcode is never lost to a write aimed at an earlier one
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			trap_q <= 1'b0;
		end else if (trap_hit) begin
			trap_q <= 1'b1;
		end else if (wr_ctrl && !io_wdata_i[`TIEC_TRAP_BIT]) begin
			trap_q <= 1'b0;
		end
	end

	// Faulting byte position flag, updated on each trap
	// and held otherwise, so software can read it long after the entry
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			pos_q <= 1'b0;
		end else if (trap_hit) begin
			pos_q <= undef_third_byte_i;
		end
	end

	// Per-input enables, bits 5..3 not stored
	// Reset leaves level 0 enabled, so one enable instruction opens it
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			in_en_q <= `TIEC_EN_RST;
		end else if (wr_ctrl) begin
			in_en_q <= io_wdata_i[`TIEC_EN2_BIT:`TIEC_EN0_BIT];
		end
	end

	// Global and shadow enable flags
	// Only one event moves the flags in a cycle; the order of the branches is
	// the priority: non-maskable accept, maskable accept, disable, enable,
	// then return from the non-maskable routine
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			gie_q    <= 1'b0;
			shadow_q <= 1'b0;
		end else if (accept_nmi) begin
			shadow_q <= gie_q;
			gie_q    <= 1'b0;
		end else if (accept_mask) begin
			gie_q    <= 1'b0;
			shadow_q <= 1'b0;
		end else if (disable_interrupts_instruction_i) begin
			gie_q    <= 1'b0;
			shadow_q <= 1'b0;
		end else if (enable_interrupts_instruction_i) begin
			gie_q    <= 1'b1;
			shadow_q <= 1'b1;
		end else if (return_from_non_maskable_i) begin
			gie_q <= shadow_q;
		end
	end

	// Level 0 mode select, mode 0 after reset
	// Code 3 names no mode and is ignored
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			mode_q <= TIEC_MODE0;
		end else if (mode_set_en_i && mode_set_i != 2'h3) begin
			mode_q <= tiec_mode_t'(mode_set_i);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// NMI edge latch, held until accepted
	// A new falling edge in the accept cycle wins, so no edge is lost;
	// the previous-level flop reads only the second synchroniser stage
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			nmi_prev_q <= 1'b1;
			nmi_pend_q <= 1'b0;
		end else begin
			nmi_prev_q <= pin_sync_q[0];
			if (nmi_fall) begin
				nmi_pend_q <= 1'b1;
			end else if (accept_nmi) begin
				nmi_pend_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Qualified maskable requests, one per external level; a level asks only
	// while the global flag and its own enable bit are both set
	logic [2:0] lvl_req;
	for (genvar g = 0; g < 3; g++) begin : g_lvl
		assign lvl_req[g] = gie_q && in_en_q[g] && !pin_sync_q[g + 1];
	end

	// Priority selection at the sample point; the choice stands until the
	// sequencer accepts it or the next sample point, so a pin released in between does not retract it
	tiec_acc_t acc_d;
	always_comb begin
		acc_d = acc_q;
		if (int_accept_i) begin
			acc_d = TIEC_ACC_NONE;
		end
		if (sample_point_i) begin
			if (nmi_pend_q) begin
				acc_d = TIEC_ACC_NMI;
			end else if (lvl_req[0]) begin
				acc_d = TIEC_ACC_MASKABLE_LEVEL0_INPUT;
			end else if (lvl_req[1]) begin
				acc_d = TIEC_ACC_MASKABLE_LEVEL1_INPUT;
			end else if (lvl_req[2]) begin
				acc_d = TIEC_ACC_MASKABLE_LEVEL2_INPUT;
			end else begin
				acc_d = TIEC_ACC_NONE;
			end
		end
	end

	// Selected kind, held for the accept decode
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			acc_q <= TIEC_ACC_NONE;
		end else begin
			acc_q <= acc_d;
		end
	end

	// Internal sources are refused while the global flag is low; their own
	// enables live in the peripherals, outside this block
	logic internal_ok;
	assign internal_ok = internal_req_i && gie_q;

	////////////////////////////////////////////////////////////////////////
	// Trap sequence strobes: request and insert state together, then the
	// guard that keeps bus release, refresh, DMA and wait out of the next state
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			trap_req_o          <= 1'b0;
			trap_insert_state_o <= 1'b0;
			inhibit_insert_o    <= 1'b0;
		end else begin
			trap_req_o          <= trap_hit;
			trap_insert_state_o <= trap_hit;
			inhibit_insert_o    <= trap_insert_state_o;
		end
	end

	// Stack push strobe; a level 0 mode 0 accept pushes nothing, since the
	// instruction fetched from the data bus does its own stacking
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			push_pc_o <= 1'b0;
		end else begin
			push_pc_o <= trap_hit || accept_nmi ||
				(accept_mask && !(acc_q == TIEC_ACC_MASKABLE_LEVEL0_INPUT && mode_q == TIEC_MODE0));
		end
	end

	// Restart address, held until the next event that names one; the trap
	// wins when it lands together with an accept
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			restart_addr_o <= `TIEC_TRAP_VEC;
		end else if (trap_hit) begin
			restart_addr_o <= `TIEC_TRAP_VEC;
		end else if (accept_nmi) begin
			restart_addr_o <= `TIEC_NMI_VEC;
		end else if (accept_mask && acc_q == TIEC_ACC_MASKABLE_LEVEL0_INPUT && mode_q == TIEC_MODE1) begin
			restart_addr_o <= `TIEC_MODE1_VEC;
		end
	end

	// Request status for the sequencer
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			irq_valid_o <= 1'b0;
			irq_kind_o  <= 3'h0;
		end else begin
			irq_valid_o <= (acc_d != TIEC_ACC_NONE) || internal_ok;
			irq_kind_o  <= acc_d;
		end
	end

	// Level 0 mode view
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			level0_mode_o <= 2'h0;
		end else begin
			level0_mode_o <= mode_q;
		end
	end

	// Parity flag copy for the load-special instructions; the written value
	// stands until the next such load
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			parity_flag_o    <= 1'b0;
			parity_flag_we_o <= 1'b0;
		end else begin
			parity_flag_we_o <= load_a_special_i;
			if (load_a_special_i) begin
				parity_flag_o <= gie_q;
			end
		end
	end

	// Enable flag views, one cycle behind the flags themselves
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			global_enable_flag_o <= 1'b0;
			shadow_enable_flag_o <= 1'b0;
		end else begin
			global_enable_flag_o <= gie_q;
			shadow_enable_flag_o <= shadow_q;
		end
	end

	// Register read port; bits 5..3 always read zero, other addresses give zero
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			io_rdata_o <= 8'h00;
		end else if (io_rd_i && io_addr_i == `TIEC_CTRL_ADDR) begin
			io_rdata_o <= {trap_q, pos_q, 3'h0, in_en_q};
		end else begin
			io_rdata_o <= 8'h00;
		end
	end

endmodule
`default_nettype wire
